// *** rma_core.sv ***
// register move alu: read-modify-write datapath, carry and branch test
module rma_core #(
    parameter int REG_COUNT = 96
) (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               cmd_valid,
    input  wire rma_pkg::rma_cmd_t  cmd,
    input  wire logic               test_valid,
    input  wire rma_pkg::rma_test_t test,
    input  wire rma_pkg::rma_cy_t   carry_cmd,
    output logic                    busy,
    output logic                    done,
    output logic                    bad_index,
    output logic                    carry_flag,
    output logic                    test_done,
    output logic                    test_taken,
    output logic [7:0]              first_byte_received_reg
);

    initial begin
        if (REG_COUNT != int'(rma_pkg::REG_COUNT)) begin
            $error("rma_core: register count must match the index range");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        RMA_ST_IDLE,
        RMA_ST_READ,
        RMA_ST_WRITE
    } rma_state_t;

    rma_state_t        state_reg, state_next;
    rma_pkg::rma_cmd_t cmd_reg, cmd_next;
    logic              carry_reg, carry_next;
    logic [7:0]        fbr_reg, fbr_next;
    logic              done_reg, done_next;
    logic              bad_reg, bad_next;
    logic              tdone_reg, tdone_next;
    logic              taken_reg, taken_next;
    logic              busy_reg, busy_next;

    logic [6:0]        src_index;
    logic [6:0]        dst_index;
    logic [7:0]        rd_data;
    logic [7:0]        src_byte;
    logic [8:0]        alu_wide;
    logic [7:0]        result;
    logic              alu_carry;
    logic              alu_sets_carry;
    logic              wr_en;
    logic              match;

    ////////////////////////////////////////////////////////////////////////
    // source and destination from the mode
    always_comb begin
        src_index = cmd_reg.reg_index;
        dst_index = cmd_reg.reg_index;
        case (cmd_reg.mode)
            rma_pkg::RMA_MODE_TO_FBR:   dst_index = rma_pkg::FBR_INDEX;
            rma_pkg::RMA_MODE_FROM_FBR: src_index = rma_pkg::FBR_INDEX;
            default:                    dst_index = cmd_reg.reg_index;
        endcase
    end

    rma_regfile #(
        .DEPTH (REG_COUNT),
        .AW    (rma_pkg::REG_INDEX_W)
    ) u_regfile (
        .clk     (clk),
        .rd_addr (src_index),
        .rd_data (rd_data),
        .wr_en   (wr_en),
        .wr_addr (dst_index),
        .wr_data (result)
    );

    // the fbr copy is authoritative; the memory slot is kept only as backing
    assign src_byte = (src_index == rma_pkg::FBR_INDEX) ? fbr_reg : rd_data;

    ////////////////////////////////////////////////////////////////////////
    // alu
    always_comb begin
        alu_wide       = {1'b0, src_byte};
        alu_sets_carry = 1'b0;
        case (cmd_reg.op)
            rma_pkg::RMA_OP_LOAD:
                alu_wide = {1'b0, cmd_reg.byte_immediate};
            rma_pkg::RMA_OP_OR:
                alu_wide = {1'b0, src_byte | cmd_reg.byte_immediate};
            rma_pkg::RMA_OP_AND:
                alu_wide = {1'b0, src_byte & cmd_reg.byte_immediate};
            rma_pkg::RMA_OP_ADD: begin
                alu_wide = {1'b0, src_byte} + {1'b0, cmd_reg.byte_immediate}
                         + {8'h00, cmd_reg.with_carry & carry_reg};
                alu_sets_carry = 1'b1;
            end
            rma_pkg::RMA_OP_SUB: begin
                alu_wide = {1'b0, src_byte} - {1'b0, cmd_reg.byte_immediate};
                alu_sets_carry = 1'b1;
            end
            default:
                alu_wide = {1'b0, src_byte};
        endcase
    end

    assign result    = alu_wide[7:0];
    assign alu_carry = alu_wide[8];
    assign wr_en     = (state_reg == RMA_ST_WRITE);
    assign match     = ((fbr_reg ^ test.compare_data) & ~test.compare_mask)
                       == 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // sequencer and carry
    always_comb begin
        state_next = state_reg;
        cmd_next   = cmd_reg;
        carry_next = carry_reg;
        fbr_next   = fbr_reg;
        done_next  = 1'b0;
        bad_next   = 1'b0;
        tdone_next = 1'b0;
        taken_next = taken_reg;
        case (state_reg)
            RMA_ST_IDLE: begin
                if (cmd_valid) begin
                    if (cmd.reg_index <= rma_pkg::REG_INDEX_MAX) begin
                        cmd_next   = cmd;
                        state_next = RMA_ST_READ;
                    end else begin
                        bad_next  = 1'b1;
                        done_next = 1'b1;
                    end
                end
            end
            RMA_ST_READ: begin
                state_next = RMA_ST_WRITE;
            end
            RMA_ST_WRITE: begin
                if (dst_index == rma_pkg::FBR_INDEX) begin
                    fbr_next = result;
                end
                if (alu_sets_carry) begin
                    carry_next = alu_carry;
                end
                done_next  = 1'b1;
                state_next = RMA_ST_IDLE;
            end
            default: state_next = RMA_ST_IDLE;
        endcase
        // carry commands override only when no alu write lands this cycle
        if (carry_cmd == rma_pkg::RMA_CY_SET && !wr_en) begin
            carry_next = 1'b1;
        end else if (carry_cmd == rma_pkg::RMA_CY_CLEAR && !wr_en) begin
            carry_next = 1'b0;
        end
        if (test_valid) begin
            tdone_next = 1'b1;
            if (test.use_carry) begin
                taken_next = (carry_reg == test.want_true);
            end else begin
                taken_next = (match == test.want_true);
            end
        end
        busy_next = (state_next != RMA_ST_IDLE);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= RMA_ST_IDLE;
            cmd_reg   <= '0;
            carry_reg <= rma_pkg::CARRY_RESET;
            fbr_reg   <= rma_pkg::BYTE_RESET;
            done_reg  <= 1'b0;
            bad_reg   <= 1'b0;
            tdone_reg <= 1'b0;
            taken_reg <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cmd_reg   <= cmd_next;
            carry_reg <= carry_next;
            fbr_reg   <= fbr_next;
            done_reg  <= done_next;
            bad_reg   <= bad_next;
            tdone_reg <= tdone_next;
            taken_reg <= taken_next;
            busy_reg  <= busy_next;
        end
    end

    assign busy                    = busy_reg;
    assign done                    = done_reg;
    assign bad_index               = bad_reg;
    assign carry_flag              = carry_reg;
    assign test_done               = tdone_reg;
    assign test_taken              = taken_reg;
    assign first_byte_received_reg = fbr_reg;

    ////////////////////////////////////////////////////////////////////////
    chk_add_carry_out: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state_reg == RMA_ST_WRITE && cmd_reg.op == rma_pkg::RMA_OP_ADD)
        |=> carry_flag == (({1'b0, $past(src_byte)}
                            + {1'b0, $past(cmd_reg.byte_immediate)}
                            + {8'h00, $past(cmd_reg.with_carry && carry_flag)})
                           > 9'h0ff))
        else $error("add carry not recorded");

    chk_sub_borrow: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state_reg == RMA_ST_WRITE && cmd_reg.op == rma_pkg::RMA_OP_SUB)
        |=> carry_flag == ($past(src_byte) < $past(cmd_reg.byte_immediate)))
        else $error("subtract borrow wrong");

    chk_fbr_load: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state_reg == RMA_ST_WRITE && cmd_reg.mode == rma_pkg::RMA_MODE_TO_FBR
         && cmd_reg.op == rma_pkg::RMA_OP_LOAD)
        |=> first_byte_received_reg == $past(cmd_reg.byte_immediate))
        else $error("immediate load into fbr wrong");

    chk_index_range: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state_reg == RMA_ST_IDLE && cmd_valid
         && cmd.reg_index > rma_pkg::REG_INDEX_MAX)
        |=> bad_index && done && state_reg == RMA_ST_IDLE)
        else $error("out of range index accepted");

    chk_cmd_latency: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state_reg == RMA_ST_IDLE && cmd_valid
         && cmd.reg_index <= rma_pkg::REG_INDEX_MAX)
        |=> busy ##1 busy ##1 (done && !busy))
        else $error("instruction did not finish in three cycles");

    chk_carry_set: assert property (
        @(posedge clk) disable iff (sys_rst)
        (carry_cmd == rma_pkg::RMA_CY_SET && !wr_en) |=> carry_flag)
        else $error("set carry ignored");

    chk_carry_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        (carry_cmd == rma_pkg::RMA_CY_CLEAR && !wr_en) |=> !carry_flag)
        else $error("clear carry ignored");

    chk_carry_test: assert property (
        @(posedge clk) disable iff (sys_rst)
        (test_valid && test.use_carry)
        |=> test_done && test_taken == ($past(carry_flag)
                                        == $past(test.want_true)))
        else $error("carry test wrong");

    chk_data_test: assert property (
        @(posedge clk) disable iff (sys_rst)
        (test_valid && !test.use_carry)
        |=> test_taken == (((($past(first_byte_received_reg)
            ^ $past(test.compare_data)) & ~$past(test.compare_mask)) == 8'h00)
            == $past(test.want_true)))
        else $error("data compare wrong");

    chk_or_result: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wr_en && cmd_reg.op == rma_pkg::RMA_OP_OR
         && dst_index == rma_pkg::FBR_INDEX)
        |=> first_byte_received_reg
            == ($past(src_byte) | $past(cmd_reg.byte_immediate)))
        else $error("or result wrong");

endmodule : rma_core

// *** rma_pkg.sv ***
// shared constants and types for the register move alu
package rma_pkg;

    localparam int          REG_INDEX_W     = 7;
    localparam int          DATA_W          = 8;
    localparam logic [6:0]  REG_INDEX_MAX   = 7'h5f;
    localparam logic [6:0]  REG_COUNT       = 7'h60;
    localparam logic [6:0]  FBR_INDEX       = 7'h08;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;
    localparam logic        CARRY_RESET     = 1'b0;
    localparam int          SG_STEP         = 8;
    localparam int          SG_MAX_ENTRIES  = 8192;

    typedef enum logic [2:0] {
        RMA_OP_MOVE,
        RMA_OP_LOAD,
        RMA_OP_OR,
        RMA_OP_AND,
        RMA_OP_ADD,
        RMA_OP_SUB
    } rma_op_t;

    typedef enum logic [1:0] {
        RMA_MODE_RMW,
        RMA_MODE_TO_FBR,
        RMA_MODE_FROM_FBR
    } rma_mode_t;

    typedef enum logic [1:0] {
        RMA_CY_NONE,
        RMA_CY_SET,
        RMA_CY_CLEAR
    } rma_cy_t;

    typedef struct packed {
        rma_mode_t          mode;
        rma_op_t            op;
        logic               with_carry;
        logic [6:0]         reg_index;
        logic [7:0]         byte_immediate;
    } rma_cmd_t;

    typedef struct packed {
        logic               use_carry;
        logic               want_true;
        logic [7:0]         compare_data;
        logic [7:0]         compare_mask;
    } rma_test_t;

endpackage : rma_pkg

// *** rma_regfile.sv ***
// byte register file with registered read data
module rma_regfile #(
    parameter int DEPTH = 96,
    parameter int AW    = 7
) (
    input  wire logic          clk,
    input  wire logic [AW-1:0] rd_addr,
    output logic [7:0]         rd_data,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data
);

    logic [7:0] mem [DEPTH];

    initial begin
        if (DEPTH > (1 << AW)) begin
            $error("rma_regfile: depth too large for address");
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule : rma_regfile

// *** rma_script_src.sv ***
// partner model: issues register instructions as a fetched script would
module rma_script_src (
    input  wire logic         clk,
    input  wire logic         done,
    input  wire logic         bad_index,
    output rma_pkg::rma_cmd_t cmd,
    output logic              cmd_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one instruction per call, single register or fbr forms only
    task automatic issue(input rma_pkg::rma_cmd_t c, output logic bad,
                         output logic ok);
        int n;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd       <= c;
        @(posedge clk);
        cmd_valid <= 1'b0;
        // released fields carry garbage, not the last value
        cmd       <= rma_pkg::rma_cmd_t'(~c);
        ok = 1'b0;
        bad = 1'b0;
        // a refused index answers on the taking edge itself
        for (n = 0; n < 8 && !ok; n++) begin
            #1;
            if (done === 1'b1) begin
                ok  = 1'b1;
                bad = bad_index;
            end else begin
                @(posedge clk);
            end
        end
    endtask : issue
endmodule : rma_script_src

// *** rma_core_tb_top.sv ***
// self-checking testbench for the register move alu
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %0h exp %0h", $time, g, e); end end
module rma_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] SG_LO = 7'h10;
    localparam logic [6:0] SG_HI = 7'h11;
    localparam logic [6:0] FBR   = rma_pkg::FBR_INDEX;

    logic               clk = 1'b0;
    logic               sys_rst, cmd_valid, test_valid;
    rma_pkg::rma_cmd_t  cmd;
    rma_pkg::rma_test_t test;
    rma_pkg::rma_cy_t   carry_cmd;
    logic               busy, done, bad_index, carry_flag;
    logic               test_done, test_taken;
    logic [7:0]         first_byte_received_reg;
    logic [7:0]         mem [0:95];
    logic               cy;
    int                 failures = 0;
    int                 tests_run = 0;
    int                 cycles = 0;

    always #5 clk = ~clk;

    rma_core u_dut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd(cmd), .test_valid(test_valid), .test(test),
        .carry_cmd(carry_cmd), .busy(busy), .done(done),
        .bad_index(bad_index), .carry_flag(carry_flag),
        .test_done(test_done), .test_taken(test_taken),
        .first_byte_received_reg(first_byte_received_reg));

    rma_script_src u_src (.clk(clk), .done(done), .bad_index(bad_index),
        .cmd(cmd), .cmd_valid(cmd_valid));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // expected {carry, result}
    function automatic logic [8:0] alu(rma_pkg::rma_op_t o, logic [7:0] a,
                                       logic [7:0] b, logic ai, logic ci);
        case (o)
            rma_pkg::RMA_OP_LOAD: return {ci, b};
            rma_pkg::RMA_OP_OR:   return {ci, a | b};
            rma_pkg::RMA_OP_AND:  return {ci, a & b};
            rma_pkg::RMA_OP_ADD:  return {1'b0, a} + {1'b0, b} + {8'h00, ai};
            rma_pkg::RMA_OP_SUB:  return {a < b, a - b};
            default:              return {ci, a};
        endcase
    endfunction : alu

    function automatic rma_pkg::rma_cmd_t mk(rma_pkg::rma_mode_t m,
        rma_pkg::rma_op_t o, logic w, logic [6:0] i, logic [7:0] d);
        return '{m, o, w, i, d};
    endfunction : mk

    task automatic run(input rma_pkg::rma_cmd_t c);
        logic       bad, ok;
        logic [8:0] r;
        logic [7:0] src;
        logic [6:0] dst;
        u_src.issue(c, bad, ok);
        `CHK(ok, 1'b1)
        `CHK(bad, c.reg_index > rma_pkg::REG_INDEX_MAX)
        if (c.reg_index <= rma_pkg::REG_INDEX_MAX) begin
            src = (c.mode == rma_pkg::RMA_MODE_FROM_FBR) ? mem[FBR]
                                                         : mem[c.reg_index];
            r = alu(c.op, src, c.byte_immediate, c.with_carry & cy, cy);
            dst = (c.mode == rma_pkg::RMA_MODE_TO_FBR) ? FBR : c.reg_index;
            mem[dst] = r[7:0];
            cy = r[8];
        end
        `CHK(first_byte_received_reg, mem[FBR])
        `CHK(carry_flag, cy)
    endtask : run

    task automatic brtest(input rma_pkg::rma_test_t t);
        logic hit;
        hit = t.use_carry ? cy
            : (((mem[FBR] ^ t.compare_data) & ~t.compare_mask) == 8'h00);
        @(posedge clk);
        test_valid <= 1'b1;
        test       <= t;
        @(posedge clk);
        test_valid <= 1'b0;
        test       <= rma_pkg::rma_test_t'(~t);
        #1;
        `CHK(test_done, 1'b1)
        `CHK(test_taken, hit == t.want_true)
    endtask : brtest

    task automatic carry_force(input logic s);
        @(posedge clk);
        carry_cmd <= s ? rma_pkg::RMA_CY_SET : rma_pkg::RMA_CY_CLEAR;
        @(posedge clk);
        carry_cmd <= rma_pkg::RMA_CY_NONE;
        #1;
        cy = s;
        `CHK(carry_flag, s)
    endtask : carry_force

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rma_pkg::rma_cmd_t c;
        void'($urandom(77));
        sys_rst = 1'b1;
        test_valid = 1'b0;
        test = '0;
        carry_cmd = rma_pkg::RMA_CY_NONE;
        mem[FBR] = rma_pkg::BYTE_RESET;
        cy = rma_pkg::CARRY_RESET;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 96; i++) begin
            run(mk(rma_pkg::RMA_MODE_RMW, rma_pkg::RMA_OP_LOAD, 1'b0, 7'(i),
                   8'($urandom)));
        end
        // boundary sums, borrow and index edge
        run(mk(rma_pkg::RMA_MODE_RMW, rma_pkg::RMA_OP_LOAD, 0, 7'h5f, 8'hff));
        run(mk(rma_pkg::RMA_MODE_RMW, rma_pkg::RMA_OP_ADD, 0, 7'h5f, 8'h01));
        run(mk(rma_pkg::RMA_MODE_RMW, rma_pkg::RMA_OP_ADD, 1, 7'h5f, 8'h00));
        run(mk(rma_pkg::RMA_MODE_RMW, rma_pkg::RMA_OP_SUB, 0, 7'h5f, 8'h02));
        run(mk(rma_pkg::RMA_MODE_RMW, rma_pkg::RMA_OP_LOAD, 0, 7'h60, 8'h55));
        for (int k = 0; k < 150; k++) begin
            c.mode = rma_pkg::rma_mode_t'($urandom_range(2, 0));
            c.op = rma_pkg::rma_op_t'($urandom_range(5, 0));
            c.with_carry = (c.op == rma_pkg::RMA_OP_ADD) && $urandom_range(1);
            c.reg_index = 7'($urandom_range(($urandom_range(15) == 0) ? 127 : 95));
            c.byte_immediate = 8'($urandom);
            run(c);
            // and a register with a random mask into fbr, then move fbr to a register
            run(mk(rma_pkg::RMA_MODE_TO_FBR, rma_pkg::RMA_OP_AND, 0,
                   7'($urandom_range(95)), 8'($urandom)));
            run(mk(rma_pkg::RMA_MODE_FROM_FBR, rma_pkg::RMA_OP_MOVE, 0,
                   7'($urandom_range(95)), 8'h00));
            brtest(rma_pkg::rma_test_t'({$urandom_range(3) == 0,
                   1'($urandom), mem[FBR] ^ 8'($urandom_range(1)),
                   8'($urandom)}));
            if (k % 8 == 0) carry_force(1'($urandom));
        end
        // base pointer stepped by 8 per pass with carry into high byte
        run(mk(rma_pkg::RMA_MODE_RMW, rma_pkg::RMA_OP_LOAD, 0, SG_LO, 8'he0));
        run(mk(rma_pkg::RMA_MODE_RMW, rma_pkg::RMA_OP_LOAD, 0, SG_HI, 8'h00));
        for (int k = 0; k < 40; k++) begin
            run(mk(rma_pkg::RMA_MODE_TO_FBR, rma_pkg::RMA_OP_ADD, 0, SG_LO,
                   8'h08));
            if (cy) run(mk(rma_pkg::RMA_MODE_RMW, rma_pkg::RMA_OP_ADD, 0,
                           SG_HI, 8'h01));
            run(mk(rma_pkg::RMA_MODE_FROM_FBR, rma_pkg::RMA_OP_MOVE, 0,
                   SG_LO, 8'h00));
        end
        run(mk(rma_pkg::RMA_MODE_TO_FBR, rma_pkg::RMA_OP_MOVE, 0, SG_HI, 0));
        `CHK(first_byte_received_reg, 8'h02)
        run(mk(rma_pkg::RMA_MODE_TO_FBR, rma_pkg::RMA_OP_MOVE, 0, SG_LO, 0));
        `CHK(first_byte_received_reg, 8'h20)
        end_of_test();
    end
endmodule : rma_core_tb_top
